/* rtl/atc_regs.svh */
// offsets, field positions, reset values and unlock keys of the analog test control bank
// Contract
// - right sub-block power bits: 0 down, 1 up
// - right mute and mute-dummy power bits, reset 0
// - whole-power-down impedance bit: 0 down, 1 up
// - pump override enable bit 4 gates select
// - pump select bit 0, resets 1, 1=constant current
// - halt detector power bit 4, resets 1
// - halt detector boost bit 1: 1 gives x4
// - halt detector disable bit 0; disabled reads 1
// - bandgap test power bit 0, resets 0
// - both password words must match to unlock
// - locked: test writes ignored, reads return zero
// - four-bit test mode field, modes 0 to 7
// - eight-bit signed left differential offset trim
// - reserved bits read/write, reset zero, no effect
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// ******************************************
// register offsets
// ******************************************
`define ATC_OFS_RIGHT_POWER     8'h29
`define ATC_OFS_PUMP_MODE       8'h2a
`define ATC_OFS_HALT_DET        8'h2b
`define ATC_OFS_BANDGAP         8'h2c
`define ATC_OFS_UNLOCK_A        8'h3f
`define ATC_OFS_UNLOCK_B        8'h40
`define ATC_OFS_TEST_MODE       8'h41
`define ATC_OFS_DIFF_TRIM       8'h46

// ******************************************
// reset values
// ******************************************
`define ATC_RST_RIGHT_POWER     8'h00
`define ATC_RST_PUMP_MODE       8'h01
`define ATC_RST_HALT_DET        8'h10
`define ATC_RST_BANDGAP         8'h00
`define ATC_RST_UNLOCK          8'h00
`define ATC_RST_TEST_MODE       8'h00
`define ATC_RST_DIFF_TRIM       8'h00

// ******************************************
// field positions
// ******************************************
`define ATC_BIT_GAIN_CTL        7
`define ATC_BIT_MUTE            6
`define ATC_BIT_MUTE_DUMMY      5
`define ATC_BIT_OFFSET_CAL      3
`define ATC_BIT_SHORT_PROT      2
`define ATC_BIT_IMP_SENSE       1
`define ATC_BIT_IMP_WHOLE       0
`define ATC_BIT_PUMP_OVR_EN     4
`define ATC_BIT_PUMP_SELECT     0
`define ATC_BIT_HALT_POWER      4
`define ATC_BIT_HALT_BOOST      1
`define ATC_BIT_HALT_DISABLE    0
`define ATC_BIT_BANDGAP         0
`define ATC_TEST_MODE_MSB       3

// ******************************************
// unlock keys (arbitrary values, nonzero so reset is locked)
// ******************************************
`define ATC_KEY_A               8'h5a
`define ATC_KEY_B               8'hc3

`endif

/* rtl/atc_pkg.sv */
// types shared by the analog test control bank
package atc_pkg;

    // one register port request, sampled every clock
    typedef struct packed {
        logic       wr;     // write strobe
        logic       rd;     // read strobe
        logic [7:0] addr;   // register offset
        logic [7:0] wdata;  // write data
    } regReq_t;

    // right channel sub-block power states, 1 = powered up
    typedef struct packed {
        logic gainCtl;
        logic mute;
        logic muteDummy;
        logic offsetCal;
        logic shortProt;
        logic impSense;
        logic impWhole;
    } rightPower_t;

    // test mode encodings of the test mode field
    typedef enum logic [3:0] {
        TM_NORMAL = 4'h0,
        TM_SCAN   = 4'h1,
        TM_IDDQ   = 4'h2,
        TM_OUT_HI = 4'h3,
        TM_OUT_LO = 4'h4,
        TM_IN_LO  = 4'h5,
        TM_IN_HI  = 4'h6,
        TM_HIGH_Z = 4'h7
    } testMode_t;

endpackage

/* rtl/byte_reg.sv */
// one byte-wide software register with a constant reset value
`timescale 1ns/1ns
module byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] value
);
    logic [7:0] value_reg;   // stored byte, reserved bits included
    logic [7:0] value_next;

    // next value: load on write, else hold
    always_comb begin
        value_next = value_reg;
        if (wrEn) begin
            value_next = wrData;
        end
    end

    // storage flop, async reset to the constant
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule // byte_reg

/* rtl/unlock_check.sv */
// two password words and the comparison that opens the test registers
`timescale 1ns/1ns
`include "atc_regs.svh"
module unlock_check (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       wrA,
    input  wire logic       wrB,
    input  wire logic [7:0] wrData,
    output logic      [7:0] wordA,
    output logic      [7:0] wordB,
    output logic            unlocked
);
    logic [7:0] wordA_reg;   // first password word
    logic [7:0] wordB_reg;   // second password word
    logic [7:0] wordA_next;
    logic [7:0] wordB_next;

    // next values of both words
    always_comb begin
        wordA_next = wrA ? wrData : wordA_reg;
        wordB_next = wrB ? wrData : wordB_reg;
    end

    // word flops, zero after reset so the bank starts locked
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wordA_reg <= `ATC_RST_UNLOCK;
            wordB_reg <= `ATC_RST_UNLOCK;
        end else begin
            wordA_reg <= wordA_next;
            wordB_reg <= wordB_next;
        end
    end

    // open only while both words hold their keys; any change relocks
    assign unlocked = (wordA_reg == `ATC_KEY_A) && (wordB_reg == `ATC_KEY_B);
    assign wordA    = wordA_reg;
    assign wordB    = wordB_reg;
endmodule // unlock_check

/* rtl/analog_test_control_regs.sv */
// analog test and control register bank with password lock
`timescale 1ns/1ns
`include "atc_regs.svh"
module analog_test_control_regs (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire atc_pkg::regReq_t     regReq,
    output logic [7:0]                readData,
    output logic                      readValid,
    input  wire logic                 haltDetRaw,
    input  wire logic                 pumpModeAuto,
    output atc_pkg::rightPower_t      rightPower,
    output logic                      pumpModeEff,
    output logic                      haltDetPower,
    output logic                      haltDetBoost,
    output logic                      haltDetOut,
    output logic                      bandgapTestPower,
    output atc_pkg::testMode_t        testMode,
    output logic [7:0]                diffOffsetTrim,
    output logic                      testUnlocked
);
    // ******************************************
    // address decode
    // ******************************************
    logic       hitPower;      // right power state register
    logic       hitPump;       // pump mode register
    logic       hitHalt;       // halt detector register
    logic       hitBandgap;    // bandgap test register
    logic       hitUnlockA;    // first password word
    logic       hitUnlockB;    // second password word
    logic       hitTestMode;   // test mode register
    logic       hitTrim;       // differential offset trim
    logic       hitTest;       // any lock-guarded register
    logic       unlocked;      // comparison result of both words
    logic       testWrOk;      // write to a guarded register allowed

    // which register the request names
    always_comb begin
        hitPower    = (regReq.addr == `ATC_OFS_RIGHT_POWER);
        hitPump     = (regReq.addr == `ATC_OFS_PUMP_MODE);
        hitHalt     = (regReq.addr == `ATC_OFS_HALT_DET);
        hitBandgap  = (regReq.addr == `ATC_OFS_BANDGAP);
        hitUnlockA  = (regReq.addr == `ATC_OFS_UNLOCK_A);
        hitUnlockB  = (regReq.addr == `ATC_OFS_UNLOCK_B);
        hitTestMode = (regReq.addr == `ATC_OFS_TEST_MODE);
        hitTrim     = (regReq.addr == `ATC_OFS_DIFF_TRIM);
        hitTest     = hitPower | hitPump | hitHalt | hitBandgap | hitTestMode | hitTrim;
        // a locked bank drops writes to guarded registers
        testWrOk    = regReq.wr & unlocked;
    end

    // ******************************************
    // storage
    // ******************************************
    logic [7:0] powerByte;     // right power state byte
    logic [7:0] pumpByte;      // pump mode byte
    logic [7:0] haltByte;      // halt detector byte
    logic [7:0] bandgapByte;   // bandgap byte
    logic [7:0] testModeByte;  // test mode byte
    logic [7:0] trimByte;      // offset trim byte
    logic [7:0] wordA;         // first password word
    logic [7:0] wordB;         // second password word

    // password words, always writable
    unlock_check u_unlock (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .wrA      (regReq.wr & hitUnlockA),
        .wrB      (regReq.wr & hitUnlockB),
        .wrData   (regReq.wdata),
        .wordA    (wordA),
        .wordB    (wordB),
        .unlocked (unlocked)
    );

    // right power states, all reset to powered down
    byte_reg #(.RESET_VAL(`ATC_RST_RIGHT_POWER)) u_power (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrEn    (testWrOk & hitPower),
        .wrData  (regReq.wdata),
        .value   (powerByte)
    );

    // pump mode, select resets to constant current
    byte_reg #(.RESET_VAL(`ATC_RST_PUMP_MODE)) u_pump (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrEn    (testWrOk & hitPump),
        .wrData  (regReq.wdata),
        .value   (pumpByte)
    );

    // halt detector, powered after reset
    byte_reg #(.RESET_VAL(`ATC_RST_HALT_DET)) u_halt (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrEn    (testWrOk & hitHalt),
        .wrData  (regReq.wdata),
        .value   (haltByte)
    );

    // bandgap test power, driven from its bit whatever the test mode
    byte_reg #(.RESET_VAL(`ATC_RST_BANDGAP)) u_bandgap (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrEn    (testWrOk & hitBandgap),
        .wrData  (regReq.wdata),
        .value   (bandgapByte)
    );

    // test mode select
    byte_reg #(.RESET_VAL(`ATC_RST_TEST_MODE)) u_test_mode (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrEn    (testWrOk & hitTestMode),
        .wrData  (regReq.wdata),
        .value   (testModeByte)
    );

    // signed offset trim, whole byte passed to the compensator
    byte_reg #(.RESET_VAL(`ATC_RST_DIFF_TRIM)) u_trim (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrEn    (testWrOk & hitTrim),
        .wrData  (regReq.wdata),
        .value   (trimByte)
    );

    // ******************************************
    // derived controls
    // ******************************************
    logic pumpModeEff_reg;   // mode actually applied to the pump
    logic pumpModeEff_next;
    logic haltDetOut_reg;    // detector result seen by the clock logic
    logic haltDetOut_next;
    logic unlocked_reg;      // lock status for observation
    logic unlocked_next;

    // override picks the register select, else the automatic mode
    always_comb begin
        pumpModeEff_next = pumpByte[`ATC_BIT_PUMP_OVR_EN] ? pumpByte[`ATC_BIT_PUMP_SELECT]
                                                           : pumpModeAuto;
        // a disabled detector reports a steady one
        haltDetOut_next  = haltByte[`ATC_BIT_HALT_DISABLE] ? 1'b1 : haltDetRaw;
        unlocked_next    = unlocked;
    end

    // derived control flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pumpModeEff_reg <= 1'b0;
            haltDetOut_reg  <= 1'b1;
            unlocked_reg    <= 1'b0;
        end else begin
            pumpModeEff_reg <= pumpModeEff_next;
            haltDetOut_reg  <= haltDetOut_next;
            unlocked_reg    <= unlocked_next;
        end
    end

    // ******************************************
    // read path
    // ******************************************
    logic [7:0] readData_reg;    // read answer
    logic [7:0] readData_next;
    logic       readValid_reg;   // one-cycle answer strobe
    logic       readValid_next;

    // select the addressed byte; guarded bytes read zero while locked
    always_comb begin
        readData_next  = 8'h00;
        readValid_next = regReq.rd;
        if (regReq.rd) begin
            if (hitUnlockA) begin
                readData_next = wordA;
            end else if (hitUnlockB) begin
                readData_next = wordB;
            end else if (hitTest && unlocked) begin
                unique case (1'b1)
                    hitPower:    readData_next = powerByte;
                    hitPump:     readData_next = pumpByte;
                    hitHalt:     readData_next = haltByte;
                    hitBandgap:  readData_next = bandgapByte;
                    hitTestMode: readData_next = testModeByte;
                    hitTrim:     readData_next = trimByte;
                    default:     readData_next = 8'h00;
                endcase
            end
        end
    end

    // read answer flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readData_reg  <= 8'h00;
            readValid_reg <= 1'b0;
        end else begin
            readData_reg  <= readData_next;
            readValid_reg <= readValid_next;
        end
    end

    // ******************************************
    // outputs
    // ******************************************
    assign rightPower.gainCtl   = powerByte[`ATC_BIT_GAIN_CTL];
    assign rightPower.mute      = powerByte[`ATC_BIT_MUTE];
    assign rightPower.muteDummy = powerByte[`ATC_BIT_MUTE_DUMMY];
    assign rightPower.offsetCal = powerByte[`ATC_BIT_OFFSET_CAL];
    assign rightPower.shortProt = powerByte[`ATC_BIT_SHORT_PROT];
    assign rightPower.impSense  = powerByte[`ATC_BIT_IMP_SENSE];
    assign rightPower.impWhole  = powerByte[`ATC_BIT_IMP_WHOLE];
    assign pumpModeEff          = pumpModeEff_reg;
    assign haltDetPower         = haltByte[`ATC_BIT_HALT_POWER];
    assign haltDetBoost         = haltByte[`ATC_BIT_HALT_BOOST];
    assign haltDetOut           = haltDetOut_reg;
    assign bandgapTestPower     = bandgapByte[`ATC_BIT_BANDGAP];
    assign testMode             = atc_pkg::testMode_t'(testModeByte[`ATC_TEST_MODE_MSB:0]);
    assign diffOffsetTrim       = trimByte;
    assign testUnlocked         = unlocked_reg;
    assign readData             = readData_reg;
    assign readValid            = readValid_reg;

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_locked_write_drop: assert property (
        (regReq.wr && !unlocked && hitTest) |=> $stable({powerByte, pumpByte, haltByte,
                                                    bandgapByte, testModeByte, trimByte}))
        else $error("guarded register changed while locked");

    chk_locked_read_zero: assert property (
        (regReq.rd && !unlocked && hitTest) |=> (readValid && readData == 8'h00))
        else $error("locked read returned nonzero");

    chk_unlock_both_words: assert property (
        (regReq.wr && hitUnlockB && regReq.wdata == `ATC_KEY_B && wordA == `ATC_KEY_A)
        |=> unlocked ##1 testUnlocked)
        else $error("matching words did not unlock");

    chk_relock_mismatch: assert property (
        (regReq.wr && hitUnlockA && regReq.wdata != `ATC_KEY_A) |=> !unlocked ##1 !testUnlocked)
        else $error("lock stayed open after mismatch");

    chk_pump_override: assert property (
        (!pumpByte[`ATC_BIT_PUMP_OVR_EN] && $stable(pumpByte)) |=> pumpModeEff == $past(pumpModeAuto))
        else $error("pump mode taken from register without override");

    chk_pump_select: assert property (
        pumpByte[`ATC_BIT_PUMP_OVR_EN] |=> pumpModeEff == $past(pumpByte[`ATC_BIT_PUMP_SELECT]))
        else $error("override did not apply register select");

    chk_halt_forced_one: assert property (
        (regReq.wr && unlocked && hitHalt && regReq.wdata[`ATC_BIT_HALT_DISABLE]) |=> ##1 haltDetOut)
        else $error("disabled detector output not one");

    chk_power_write: assert property (
        (regReq.wr && unlocked && hitPower) |=> (rightPower.gainCtl == $past(regReq.wdata[7])
                                                 && rightPower.impWhole == $past(regReq.wdata[0])))
        else $error("right power write not applied");

    chk_reserved_readback: assert property (
        (regReq.wr && unlocked && hitPump) ##1 (regReq.rd && hitPump && unlocked && !regReq.wr)
        |=> readData == $past(regReq.wdata, 2))
        else $error("reserved bits did not read back");

    chk_test_mode_write: assert property (
        (regReq.wr && unlocked && hitTestMode) |=> testMode == $past(regReq.wdata[3:0]))
        else $error("test mode field not written");
endmodule // analog_test_control_regs

/* verif/analog_test_control_regs_bench.sv */
// self-checking testbench for the analog test control register bank
`timescale 1ns/1ns
`include "atc_regs.svh"
module analog_test_control_regs_bench;

    // ****************************************
    // signals around the design
    // ****************************************
    logic                 clk_sys;          // 125 MHz system clock
    logic                 reset_n;          // async reset, active low
    atc_pkg::regReq_t     regReq;           // register port request
    logic [7:0]           readData;         // read answer
    logic                 readValid;        // read answer strobe
    logic                 haltDetRaw;       // raw halt detector level
    logic                 pumpModeAuto;     // pump mode without override
    atc_pkg::rightPower_t rightPower;       // right sub-block power states
    logic                 pumpModeEff;      // applied pump mode
    logic                 haltDetPower;     // halt detector power
    logic                 haltDetBoost;     // halt detector x4 current
    logic                 haltDetOut;       // halt detector result
    logic                 bandgapTestPower; // bandgap test power
    atc_pkg::testMode_t   testMode;         // test mode field
    logic [7:0]           diffOffsetTrim;   // left diff offset trim
    logic                 testUnlocked;     // lock open flag
    int                   errTotal;         // mismatches seen
    int                   nChecks;          // comparisons made
    int                   cycleCount;       // cycles since start
    logic [7:0]           wVal;             // value being written
    logic [6:0]           pExp;             // expected power vector

    analog_test_control_regs dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .regReq(regReq), .readData(readData),
        .readValid(readValid), .haltDetRaw(haltDetRaw), .pumpModeAuto(pumpModeAuto),
        .rightPower(rightPower), .pumpModeEff(pumpModeEff), .haltDetPower(haltDetPower),
        .haltDetBoost(haltDetBoost), .haltDetOut(haltDetOut),
        .bandgapTestPower(bandgapTestPower), .testMode(testMode),
        .diffOffsetTrim(diffOffsetTrim), .testUnlocked(testUnlocked)
    );

    // ****************************************
    // clock and hang guard
    // ****************************************
    // free running clock, 8 ns period
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // the whole run takes well under 2000 cycles
    always @(posedge clk_sys) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            errTotal++;
            completeRun();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    // compare one value, count and report
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // counts and verdict, then stop
    task automatic completeRun();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // let n edges pass, then settle
    task automatic waitCycles(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one-cycle write strobe; returns just after the taking edge
    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys);
        regReq <= '0;
        #1;
    endtask

    // one-cycle read strobe, answer awaited under a bound and compared
    task automatic expectRead(input logic [7:0] addr, input logic [7:0] exp);
        int k;
        @(posedge clk_sys);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_sys);
        regReq <= '0;
        #1;
        for (k = 0; k < 2 && readValid !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        check("readValid", {7'h00, readValid}, 8'h01);
        check($sformatf("read %h", addr), readData, exp);
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        reset_n      <= 1'b0;
        regReq       <= '0;
        haltDetRaw   <= 1'b0;
        pumpModeAuto <= 1'b0;
        errTotal     = 0;
        nChecks      = 0;
        cycleCount   = 0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1;

        // reset state and locked reads
        check("rightPower", {1'b0, rightPower}, 8'h00);
        check("haltDetPower", {7'h00, haltDetPower}, 8'h01);
        check("haltDetBoost", {7'h00, haltDetBoost}, 8'h00);
        check("bandgapTestPower", {7'h00, bandgapTestPower}, 8'h00);
        check("testMode", {4'h0, testMode}, 8'h00);
        check("diffOffsetTrim", diffOffsetTrim, 8'h00);
        check("testUnlocked", {7'h00, testUnlocked}, 8'h00);
        expectRead(`ATC_OFS_HALT_DET, 8'h00);
        expectRead(`ATC_OFS_PUMP_MODE, 8'h00);
        expectRead(`ATC_OFS_UNLOCK_A, 8'h00);
        @(posedge clk_sys);
        haltDetRaw   <= 1'b1;
        pumpModeAuto <= 1'b1;
        waitCycles(2);
        check("haltDetOut", {7'h00, haltDetOut}, 8'h01);
        check("pumpModeEff", {7'h00, pumpModeEff}, 8'h01);
        @(posedge clk_sys);
        haltDetRaw <= 1'b0;
        waitCycles(2);
        check("haltDetOut", {7'h00, haltDetOut}, 8'h00);
        $display("test reset done");

        // locked writes dropped, then unlock word by word
        writeReg(`ATC_OFS_RIGHT_POWER, 8'hff);
        writeReg(`ATC_OFS_TEST_MODE, 8'h07);
        check("rightPower", {1'b0, rightPower}, 8'h00);
        check("testMode", {4'h0, testMode}, 8'h00);
        writeReg(`ATC_OFS_UNLOCK_A, `ATC_KEY_A);
        writeReg(`ATC_OFS_UNLOCK_B, `ATC_KEY_B ^ 8'h01);
        waitCycles(2);
        check("testUnlocked", {7'h00, testUnlocked}, 8'h00);
        writeReg(`ATC_OFS_UNLOCK_B, `ATC_KEY_B);
        waitCycles(2);
        check("testUnlocked", {7'h00, testUnlocked}, 8'h01);
        expectRead(`ATC_OFS_PUMP_MODE, `ATC_RST_PUMP_MODE);
        expectRead(`ATC_OFS_HALT_DET, `ATC_RST_HALT_DET);
        expectRead(`ATC_OFS_RIGHT_POWER, 8'h00);
        $display("test unlock done");

        // pump override and select, pumpModeAuto high then low
        writeReg(`ATC_OFS_PUMP_MODE, 8'h10);
        waitCycles(2);
        check("pumpModeEff", {7'h00, pumpModeEff}, 8'h00);
        writeReg(`ATC_OFS_PUMP_MODE, 8'h11);
        @(posedge clk_sys);
        pumpModeAuto <= 1'b0;
        waitCycles(2);
        check("pumpModeEff", {7'h00, pumpModeEff}, 8'h01);
        writeReg(`ATC_OFS_PUMP_MODE, 8'hef);
        waitCycles(2);
        check("pumpModeEff", {7'h00, pumpModeEff}, 8'h00);
        expectRead(`ATC_OFS_PUMP_MODE, 8'hef);
        // write then read of the same byte on back-to-back edges
        @(posedge clk_sys);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: `ATC_OFS_PUMP_MODE, wdata: 8'he1};
        @(posedge clk_sys);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: `ATC_OFS_PUMP_MODE, wdata: 8'h00};
        @(posedge clk_sys);
        regReq <= '0;
        #1;
        check("readValid", {7'h00, readValid}, 8'h01);
        check("read back to back", readData, 8'he1);
        $display("test pump done");

        // walk one bit through the power byte, reserved bit included
        for (int i = 0; i < 8; i++) begin
            wVal = 8'h01 << i;
            pExp = {wVal[7:5], wVal[3:0]};
            writeReg(`ATC_OFS_RIGHT_POWER, wVal);
            check("rightPower", {1'b0, rightPower}, {1'b0, pExp});
            expectRead(`ATC_OFS_RIGHT_POWER, wVal);
        end
        $display("test power done");

        // halt detector controls, disabled output forced high
        writeReg(`ATC_OFS_HALT_DET, 8'h13);
        waitCycles(2);
        check("haltDetPower", {7'h00, haltDetPower}, 8'h01);
        check("haltDetBoost", {7'h00, haltDetBoost}, 8'h01);
        check("haltDetOut", {7'h00, haltDetOut}, 8'h01);
        writeReg(`ATC_OFS_HALT_DET, 8'hec);
        waitCycles(2);
        check("haltDetPower", {7'h00, haltDetPower}, 8'h00);
        check("haltDetBoost", {7'h00, haltDetBoost}, 8'h00);
        check("haltDetOut", {7'h00, haltDetOut}, 8'h00);
        expectRead(`ATC_OFS_HALT_DET, 8'hec);
        $display("test halt done");

        // bandgap bit against its reserved neighbours
        writeReg(`ATC_OFS_BANDGAP, 8'h01);
        check("bandgapTestPower", {7'h00, bandgapTestPower}, 8'h01);
        writeReg(`ATC_OFS_BANDGAP, 8'hfe);
        check("bandgapTestPower", {7'h00, bandgapTestPower}, 8'h00);
        expectRead(`ATC_OFS_BANDGAP, 8'hfe);
        $display("test bandgap done");

        // every test mode code, reserved upper nibble set
        for (int m = 0; m < 8; m++) begin
            wVal = {4'ha, m[3:0]};
            writeReg(`ATC_OFS_TEST_MODE, wVal);
            check("testMode", {4'h0, testMode}, {4'h0, m[3:0]});
            expectRead(`ATC_OFS_TEST_MODE, wVal);
        end
        $display("test mode done");

        // trim byte extremes, then unmapped place
        for (int t = 0; t < 4; t++) begin
            wVal = (t == 0) ? 8'h80 : (t == 1) ? 8'h7f : (t == 2) ? 8'h01 : 8'hff;
            writeReg(`ATC_OFS_DIFF_TRIM, wVal);
            check("diffOffsetTrim", diffOffsetTrim, wVal);
            expectRead(`ATC_OFS_DIFF_TRIM, wVal);
        end
        writeReg(8'h30, 8'h55);
        expectRead(8'h30, 8'h00);
        $display("test trim done");

        // spoiling one word relocks; held values stay
        writeReg(`ATC_OFS_UNLOCK_A, 8'h00);
        waitCycles(2);
        check("testUnlocked", {7'h00, testUnlocked}, 8'h00);
        writeReg(`ATC_OFS_DIFF_TRIM, 8'h12);
        check("diffOffsetTrim", diffOffsetTrim, 8'hff);
        expectRead(`ATC_OFS_DIFF_TRIM, 8'h00);
        expectRead(`ATC_OFS_UNLOCK_B, `ATC_KEY_B);
        $display("test relock done");

        // second reset in mid-run
        @(posedge clk_sys);
        reset_n <= 1'b0;
        waitCycles(3);
        check("diffOffsetTrim", diffOffsetTrim, 8'h00);
        check("haltDetPower", {7'h00, haltDetPower}, 8'h01);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        waitCycles(2);
        check("testUnlocked", {7'h00, testUnlocked}, 8'h00);
        expectRead(`ATC_OFS_UNLOCK_B, 8'h00);
        expectRead(`ATC_OFS_HALT_DET, 8'h00);
        $display("test second reset done");
        completeRun();
    end

endmodule // analog_test_control_regs_bench
